// ---- rtl/cfg_access_regs.svh ----
// Constants for the token-framed configuration access protocol.
// Included by both protocol ends and the bench; definitions only.
`ifndef CFG_ACCESS_REGS_SVH
`define CFG_ACCESS_REGS_SVH
`define TOK_WRITE 8'hc0
`define TOK_READ 8'hc1
`define TOK_END 8'h01
`define TOK_ACK 8'h03
`define TOK_NACK 8'h04
`define NO_REPLY_LOW 8'hff
`define PS_RID_SHIFT 8
`define PS_RID_TAG 8'h0c
`define TILE_DEST_SUFFIX 16'hc20c
`define NODE_DEST_SUFFIX 16'hc30c
`define BANK_PS 2'h0
`define BANK_TILE 2'h1
`define BANK_NODE 2'h2
`endif

// ---- rtl/cfg_access_pkg.sv ----
// Types shared by the configuration access ends.
// Assumes it is compiled before the protocol ends that use it.
package cfg_access_pkg;
  typedef logic [1:0] bank_t;
  typedef logic [7:0] byte_t;
endpackage

// ---- rtl/cfg_link_if.sv ----
// Token link between a requesting channel end and the configuration block.
// Each byte carries a control flag; a byte moves when valid and ready are high.
`timescale 1ns/10ps
interface cfg_link_if;
  logic req_valid;
  logic req_ready;
  logic req_ctrl;
  logic [7:0] req_data;
  logic [1:0] req_bank;
  logic rsp_valid;
  logic rsp_ready;
  logic rsp_ctrl;
  logic [7:0] rsp_data;
  modport device (input req_valid, output req_ready, input req_ctrl, input req_data,
    input req_bank, output rsp_valid, input rsp_ready, output rsp_ctrl,
    output rsp_data);
  modport requester (output req_valid, input req_ready, output req_ctrl,
    output req_data, output req_bank, input rsp_valid, output rsp_ready,
    input rsp_ctrl, input rsp_data);
endinterface

// ---- rtl/cfg_requester.sv ----
// Requesting end: turns one user read or write into a token message.
// Assumes the device end answers each request that asks for a reply.
`timescale 1ns/10ps
`include "cfg_access_regs.svh"
module cfg_requester
(
  input wire logic clk,
  input wire logic srst,
  cfg_link_if.requester link,
  input wire logic start,
  input wire logic is_write,
  input wire logic [1:0] bank,
  input wire logic [23:0] reply_id,
  input wire logic [15:0] reg_num,
  input wire logic [31:0] wdata,
  output logic busy,
  output logic done,
  output logic ok,
  output logic [31:0] rdata
);
  typedef enum logic [1:0] {IDLE, SEND, WAIT} state_e;
  state_e state;
  logic [3:0] idx;
  logic [3:0] last;
  logic wr;
  logic quiet;
  cfg_access_pkg::bank_t bk;
  logic [79:0] msg;
  logic [2:0] rcnt;
  logic rfail;
  wire cur_ctrl = (idx == 4'd0) || (idx == last);
  // The message shifts out of the top byte, so no index runs past its end
  wire [7:0] cur_byte = msg[79:72];
  wire sent = link.req_valid && link.req_ready;
  wire got = link.rsp_valid && link.rsp_ready;
  wire got_end = got && link.rsp_ctrl && link.rsp_data == `TOK_END;

  assign link.req_valid = (state == SEND);
  assign link.req_ctrl = cur_ctrl;
  assign link.req_data = (idx == last) ? `TOK_END : cur_byte;
  assign link.req_bank = bk;
  assign link.rsp_ready = (state == WAIT);
  assign busy = (state != IDLE);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= IDLE;
      idx <= 4'd0;
      last <= 4'd0;
      wr <= 1'b0;
      quiet <= 1'b0;
      bk <= 2'd0;
      msg <= 80'd0;
      rcnt <= 3'd0;
      rfail <= 1'b0;
      done <= 1'b0;
      ok <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        IDLE:
          if (start)
          begin
            // Message laid out most significant byte first
            msg <= {is_write ? `TOK_WRITE : `TOK_READ, reply_id, reg_num, wdata};
            last <= is_write ? 4'd10 : 4'd6;
            wr <= is_write;
            quiet <= is_write && (reply_id[7:0] == `NO_REPLY_LOW);
            bk <= bank;
            idx <= 4'd0;
            state <= SEND;
          end
        SEND:
          if (sent)
          begin
            idx <= idx + 4'd1;
            msg <= {msg[71:0], 8'h00};
            if (idx == last)
            begin
              rcnt <= 3'd0;
              rfail <= 1'b0;
              if (quiet)
              begin
                // No answer comes back for a silenced write
                state <= IDLE;
                done <= 1'b1;
                ok <= 1'b1;
              end
              else
                state <= WAIT;
            end
          end
        WAIT:
          if (got)
          begin
            if (rcnt == 3'd0)
              rfail <= !(link.rsp_ctrl && link.rsp_data == `TOK_ACK);
            else if (!link.rsp_ctrl && rcnt <= 3'd4)
              rdata <= {rdata[23:0], link.rsp_data};
            rcnt <= rcnt + 3'd1;
            if (got_end && rcnt != 3'd0)
            begin
              state <= IDLE;
              done <= 1'b1;
              ok <= !rfail && (wr ? rcnt == 3'd1 : rcnt == 3'd5);
            end
          end
        default:
          state <= IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/cfg_device.sv ----
// Device end: parses token messages and accesses three register banks.
// Assumes the requester frames each message and takes answer bytes when ready.
`timescale 1ns/10ps
`include "cfg_access_regs.svh"
module cfg_device #(
  parameter int REGS = 16
)
(
  input wire logic clk,
  input wire logic srst,
  cfg_link_if.device link,
  output logic [31:0] status_word,
  output logic [7:0] writes_done,
  output logic [7:0] errors_seen
);
  localparam int AW = $clog2(REGS);
  typedef enum logic [2:0] {HEAD, BODY, TAIL, DROP, REPLY} state_e;
  state_e state;
  state_e next_state;
  logic wr;
  logic [3:0] cnt;
  logic [23:0] rid;
  logic [15:0] rnum;
  logic [31:0] data;
  cfg_access_pkg::bank_t bk;
  logic [2:0] ridx;
  logic [2:0] rlast;
  logic [31:0] rword;
  logic reply_ok;
  logic [31:0] mem [3][REGS];
  wire [31:0] bank_word [4];
  cfg_access_pkg::byte_t lead_tok;
  cfg_access_pkg::byte_t data_byte;

  // Request side decode
  wire take = link.req_valid && link.req_ready;
  wire is_end = link.req_ctrl && link.req_data == `TOK_END;
  wire is_write_tok = link.req_data == `TOK_WRITE;
  wire is_read_tok = link.req_data == `TOK_READ;
  wire is_lead = link.req_ctrl && (is_write_tok || is_read_tok);
  wire in_head = (state == HEAD);
  wire in_body = (state == BODY);
  wire in_tail = (state == TAIL);
  wire in_drop = (state == DROP);
  wire in_reply = (state == REPLY);
  wire [3:0] body_len = wr ? 4'd9 : 4'd5;
  wire body_last = (cnt == body_len - 4'd1);
  wire body_byte = in_body && take && !link.req_ctrl;
  wire [71:0] fields = {rid, rnum, data};
  // Writes shift the whole body; reads leave the data word clear
  wire [71:0] next_fields = wr ? {fields[63:0], link.req_data} :
    {fields[63:32], link.req_data, 32'h0000_0000};

  // Unmapped register numbers and a fourth bank fail the access
  wire in_range = (rnum < 16'(REGS)) && (bk != 2'd3);
  wire [AW-1:0] ra = rnum[AW-1:0];
  // Any unsilenced close but an in-range one after a full body answers with failure
  wire close_any = take && is_end && (in_body || in_tail || in_drop);
  wire close_good = in_tail && take && is_end && in_range;
  wire commit = close_good && wr;
  // The reply id is whole only after the body, so only a full write is silenced
  wire quiet = wr && rid[7:0] == `NO_REPLY_LOW;
  wire [31:0] rd_word = bank_word[bk];

  // Reply side: status token, data MSB first on a good read, closing token
  wire rsp_take = in_reply && link.rsp_ready;
  wire rsp_last = rsp_take && (ridx == rlast);
  wire [2:0] data_sel = ridx - 3'd1;
  assign lead_tok = reply_ok ? `TOK_ACK : `TOK_NACK;
  assign data_byte = (data_sel == 3'd0) ? rword[31:24] :
    (data_sel == 3'd1) ? rword[23:16] :
    (data_sel == 3'd2) ? rword[15:8] : rword[7:0];
  assign link.req_ready = !in_reply;
  assign link.rsp_valid = in_reply;
  assign link.rsp_ctrl = (ridx == 3'd0) || (ridx == rlast);
  assign link.rsp_data = (ridx == 3'd0) ? lead_tok :
    (ridx == rlast) ? `TOK_END : data_byte;
  assign status_word = mem[`BANK_PS][0];

  always_comb
  begin
    next_state = state;
    case (state)
      HEAD:
        if (take)
          next_state = is_lead ? BODY : DROP;
      BODY:
        if (take && link.req_ctrl)
          next_state = is_end ? REPLY : DROP;
        else if (body_byte && body_last)
          next_state = TAIL;
      TAIL:
        if (take && !is_end)
          next_state = DROP;
        else if (take && quiet)
          next_state = HEAD; // Silenced write: no answer tokens leave
        else if (take)
          next_state = REPLY;
      DROP:
        if (take && is_end)
          next_state = REPLY;
      REPLY:
        if (rsp_last)
          next_state = HEAD;
      default:
        next_state = HEAD;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state <= HEAD;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr <= 1'b0;
      cnt <= 4'd0;
      bk <= 2'd0;
    end
    else if (in_head && take)
    begin
      // Bank is chosen by the destination the requester set
      bk <= link.req_bank;
      wr <= is_write_tok;
      cnt <= 4'd0;
    end
    else if (body_byte)
      cnt <= cnt + 4'd1;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rid <= 24'd0;
      rnum <= 16'd0;
      data <= 32'h0000_0000;
    end
    else if (body_byte)
      {rid, rnum, data} <= next_fields;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ridx <= 3'd0;
      rlast <= 3'd1;
      rword <= 32'h0000_0000;
      reply_ok <= 1'b0;
    end
    else if (close_any)
    begin
      ridx <= 3'd0;
      rlast <= (close_good && !wr) ? 3'd5 : 3'd1;
      rword <= rd_word;
      reply_ok <= close_good;
    end
    else if (rsp_take && !rsp_last)
      ridx <= ridx + 3'd1;
  end

  // Counters see every close, silenced writes included
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      writes_done <= 8'h00;
      errors_seen <= 8'h00;
    end
    else if (close_any)
    begin
      if (commit)
        writes_done <= writes_done + 8'h01;
      if (!close_good)
        errors_seen <= errors_seen + 8'h01;
    end
  end

  // Register banks: one full word per write, each bank its own store
  genvar b;
  generate
    for (b = 0; b < 3; b++)
    begin : g_bank
      assign bank_word[b] = mem[b][ra];
      always_ff @(posedge clk)
      begin
        if (srst)
          mem[b] <= '{default: 32'h0000_0000};
        else if (commit && bk == 2'(b))
          mem[b][ra] <= data;
      end
    end
  endgenerate
  // No fourth bank; its reads are refused before the word is used
  assign bank_word[3] = 32'h0000_0000;
endmodule

// ---- verification/cfg_access_props.sv ----
// Checker for the token link between requester and device.
// Assumes it sees the signals of the interface joining both ends.
`timescale 1ns/10ps
`include "cfg_access_regs.svh"
module cfg_access_props
(
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic [1:0] req_bank,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data
);
  logic [3:0] idx;
  logic [2:0] rc;
  logic [7:0] lead;
  logic quiet;
  logic ack;
  wire logic qhs = req_valid && req_ready;
  wire logic rhs = rsp_valid && rsp_ready;
  wire logic close = qhs && req_ctrl && req_data == `TOK_END;
  wire logic rend = rhs && rsp_ctrl && rsp_data == `TOK_END;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk)
    if (srst)
      idx <= 4'h0;
    else if (qhs)
      idx <= close ? 4'h0 : idx + 4'h1;
  always_ff @(posedge clk)
    if (qhs && idx == 4'h0)
      lead <= req_data;
  // Low id byte is the fourth byte since the id travels high byte first
  always_ff @(posedge clk)
    if (srst || (qhs && idx == 4'h0))
      quiet <= 1'b0;
    else if (qhs && idx == 4'h3)
      quiet <= lead == `TOK_WRITE && req_data == `NO_REPLY_LOW;
  always_ff @(posedge clk)
    if (srst)
      rc <= 3'h0;
    else if (rhs)
      rc <= rend ? 3'h0 : rc + 3'h1;
  always_ff @(posedge clk)
    if (rhs && rc == 3'h0)
      ack <= rsp_data == `TOK_ACK;
  a_lead_token: assert property (qhs && idx == 4'h0 |-> req_ctrl && req_data[7:1] == 7'h60)
    else $error("request does not open with a read or write token");
  a_req_holds: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
    else $error("request byte changed before it was taken");
  a_rsp_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("reply byte changed before it was taken");
  a_busy_refuses: assert property (rsp_valid |-> !req_ready)
    else $error("device took request bytes while replying");
  a_reply_starts: assert property (close && !quiet |=> rsp_valid && rsp_ctrl)
    else $error("no reply token after the closing token");
  a_quiet_write: assert property (close && quiet |=> !rsp_valid [*4])
    else $error("reply sent for a write that asked for none");
  a_first_token: assert property (rhs && rc == 3'h0 |-> rsp_ctrl && rsp_data inside {`TOK_ACK, `TOK_NACK})
    else $error("reply does not open with success or failure token");
  a_data_plain: assert property (rhs && rc != 3'h0 && ack && lead == `TOK_READ |-> rc == 3'h5 || !rsp_ctrl)
    else $error("control token inside read data");
  a_reply_len: assert property (rend |-> rc == ((ack && lead == `TOK_READ) ? 3'h5 : 3'h1))
    else $error("reply has wrong length");
  a_bank_steady: assert property (qhs && idx != 4'h0 |-> $stable(req_bank))
    else $error("destination bank changed inside a message");
endmodule

// ---- verification/test_config_register_access_protocol.sv ----
// Testbench joining requester and device; a second device faces a rule-breaking driver.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/10ps
`include "cfg_access_regs.svh"
module test_config_register_access_protocol;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic is_write = 1'b0;
  logic [1:0] bank = 2'h0;
  logic [23:0] reply_id = 24'h00_0000;
  logic [15:0] reg_num = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  wire logic busy, done, ok;
  wire logic [31:0] rdata, status_word;
  wire logic [7:0] writes_done, errors_seen;
  localparam logic [31:0] PS_RID = (32'h0000_0000 << `PS_RID_SHIFT) | {24'h00_0000, `PS_RID_TAG};
  wire logic [15:0] ps_reg = PS_RID[`PS_RID_SHIFT +: 16];
  int n_errors = 0;
  int check_count = 0;
  logic [87:0] qsh;
  logic [47:0] rsh, rsh2;
  cfg_link_if link();
  cfg_link_if link2();
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (link.req_valid && link.req_ready) qsh <= {qsh[79:0], link.req_data};
    if (link.rsp_valid && link.rsp_ready) rsh <= {rsh[39:0], link.rsp_data};
    if (link2.rsp_valid && link2.rsp_ready) rsh2 <= {rsh2[39:0], link2.rsp_data};
  end
  cfg_requester u_cfg_requester(.clk(clk), .srst(srst), .link(link), .start(start),
    .is_write(is_write), .bank(bank), .reply_id(reply_id), .reg_num(reg_num), .wdata(wdata),
    .busy(busy), .done(done), .ok(ok), .rdata(rdata));
  cfg_device #(.REGS(16)) u_cfg_device(.clk(clk), .srst(srst), .link(link),
    .status_word(status_word), .writes_done(writes_done), .errors_seen(errors_seen));
  cfg_device #(.REGS(16)) u_cfg_device_bad(.clk(clk), .srst(srst), .link(link2),
    .status_word(), .writes_done(), .errors_seen());
  cfg_access_props u_cfg_access_props(.clk(clk), .srst(srst), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_ctrl(link.req_ctrl), .req_data(link.req_data),
    .req_bank(link.req_bank), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
    .rsp_ctrl(link.rsp_ctrl), .rsp_data(link.rsp_data));
  task chk(input string nm, input logic [87:0] got, input logic [87:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task xfer(input logic w, input logic [1:0] b, input logic [23:0] id, input logic [15:0] r,
    input logic [31:0] d, input logic eok, input logic [31:0] erd);
    int i;
    @(negedge clk);
    {start, is_write, bank, reply_id, reg_num, wdata} = {1'b1, w, b, id, r, d};
    @(negedge clk);
    start = 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge clk);
    chk("done", done, 1'b1);
    if (!w || id[7:0] != `NO_REPLY_LOW) chk("ok", ok, eok);
    if (!w && eok) chk("rdata", rdata, erd);
  endtask
  // Far side of the spare link; a stalled device would hang here, the watchdog cuts it
  task sendb(input logic c, input logic [7:0] d);
    @(negedge clk);
    {link2.req_valid, link2.req_ctrl, link2.req_data} = {1'b1, c, d};
    while (link2.req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    {link2.req_valid, link2.req_ctrl, link2.req_data, link2.req_bank} = 12'h000;
    link2.rsp_ready = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    xfer(1, 2'h0, 24'h12_3456, ps_reg, 32'ha1b2_c3d4, 1, 0);
    chk("write bytes", qsh, {`TOK_WRITE, 24'h12_3456, 16'h0000, 32'ha1b2_c3d4, `TOK_END});
    chk("write reply", rsh[15:0], {`TOK_ACK, `TOK_END});
    chk("status word", status_word, 32'ha1b2_c3d4);
    xfer(0, 2'h0, 24'h12_3456, ps_reg, 0, 1, 32'ha1b2_c3d4);
    chk("read bytes", qsh[55:0], {`TOK_READ, 24'h12_3456, 16'h0000, `TOK_END});
    chk("read reply", rsh, {`TOK_ACK, 32'ha1b2_c3d4, `TOK_END});
    for (int b = 0; b < 3; b++)
    begin
      xfer(1, b[1:0], 24'h00_0102, 16'h000f, 32'h5a5a_0000 + b, 1, 0);
      xfer(0, b[1:0], 24'h00_0102, 16'h000f, 0, 1, 32'h5a5a_0000 + b);
    end
    xfer(1, 2'h2, 24'h00_01ff, 16'h000f, 32'h0bad_f00d, 1, 0);
    xfer(0, 2'h2, 24'h00_01ff, 16'h000f, 0, 1, 32'h0bad_f00d);
    xfer(1, 2'h1, 24'h00_0102, 16'h0010, 32'h1111_2222, 0, 0);
    chk("fail reply", rsh[15:0], {`TOK_NACK, `TOK_END});
    xfer(0, 2'h3, 24'h00_0102, 16'h0000, 0, 0, 0);
    chk("writes done", writes_done, 8'h05);
    chk("errors seen", errors_seen, 8'h02);
    sendb(1'b1, 8'h55);
    sendb(1'b0, 8'h01);
    sendb(1'b0, 8'h02);
    sendb(1'b1, `TOK_END);
    @(negedge clk);
    {link2.req_valid, link2.req_data} = {1'b0, ~link2.req_data};
    repeat (10) @(negedge clk);
    chk("bad lead reply", rsh2[15:0], {`TOK_NACK, `TOK_END});
    wrap_up();
  end
endmodule
